// file: src/sar_attr_clean.sv
`timescale 1ns/1ps
`include "sar_map.svh"
module sar_attr_clean (
	// raw entry from the drive side
	input wire sar_pkg::sar_entry_t entry_in,
	input wire logic fresh,
	// entry as stored
	output sar_pkg::sar_entry_t entry_out
);
	logic [7:0] init;
	logic [7:0] value;
	logic [7:0] worst;
	logic in_use;

	always_comb
	begin
		init = (entry_in.id == `SAR_ID_CRC_ERRORS) ? `SAR_VAL_INIT_CRC : `SAR_VAL_INIT; // RULE16 RULE15
		value = fresh ? init : entry_in.value;
		worst = fresh ? init : entry_in.worst;
		in_use = (value >= `SAR_VAL_MIN) && (value <= `SAR_VAL_MAX); // RULE15
		if (in_use && (value < worst))
			worst = value;
		if (worst < `SAR_VAL_MIN)
			worst = `SAR_VAL_MIN; // RULE17
		if (worst > `SAR_WORST_MAX)
			worst = `SAR_WORST_MAX; // RULE17
		entry_out.id = entry_in.id; // RULE20
		entry_out.flags = entry_in.flags & `SAR_FLAG_KEEP; // RULE14
		entry_out.value = value;
		entry_out.worst = worst;
		entry_out.raw = (entry_in.raw > `SAR_RAW_SAT) ? `SAR_RAW_SAT : entry_in.raw; // RULE18
		entry_out.zero = 8'h00; // RULE11
		if (entry_in.id == `SAR_ID_UNUSED)
			entry_out = '0; // RULE19
	end
endmodule : sar_attr_clean

// file: src/sar_map.svh
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
// command selection
`define SAR_CMD_HEALTH 8'hb0
`define SAR_SUB_READ_ATTR 8'hd0
`define SAR_SIGNATURE 16'hc24f
// block layout, word and byte indices
`define SAR_BLOCK_WORDS 10'h100
`define SAR_LAST_WORD 8'hff
`define SAR_REVISION 16'h0010
`define SAR_ATTR_FIRST_WORD 8'h01
`define SAR_ATTR_LAST_WORD 8'hb4
`define SAR_ATTR_LAST_BYTE 9'h169
`define SAR_ENTRY_LAST_WORD 3'h5
`define SAR_SLOTS 30
`define SAR_B_OFFLINE 9'h16a
`define SAR_B_SELFTEST 9'h16b
`define SAR_B_TIME_LO 9'h16c
`define SAR_B_TIME_HI 9'h16d
`define SAR_B_OFFLINE_CAP 9'h16f
`define SAR_B_CAP_LO 9'h170
`define SAR_B_CAP_HI 9'h171
`define SAR_B_ERRLOG 9'h172
`define SAR_B_CHECKPOINT 9'h173
`define SAR_B_SHORT_POLL 9'h174
`define SAR_B_EXT_POLL 9'h175
`define SAR_W_ERRLOG 8'hb9
`define SAR_W_STATUS 8'hb5
// fixed capability contents
`define SAR_OFFLINE_CAP 8'h5b
`define SAR_SMART_CAP 16'h0003
`define SAR_ERRLOG_CAP 8'h01
`define SAR_AUTO_BIT 8'h80
// attribute value encoding
`define SAR_VAL_MIN 8'h01
`define SAR_VAL_MAX 8'hfd
`define SAR_WORST_MAX 8'hfe
`define SAR_VAL_INIT 8'h64
`define SAR_VAL_INIT_CRC 8'hc8
`define SAR_RAW_SAT 48'h0000000fffff
`define SAR_FLAG_KEEP 16'h003f
`define SAR_FLAG_PREFAIL 0
`define SAR_FLAG_ONLINE 1
// attribute identifiers
`define SAR_ID_UNUSED 8'h00
`define SAR_ID_TEMPERATURE 8'hc2
`define SAR_ID_OFFLINE_UNC 8'hc6
`define SAR_ID_CRC_ERRORS 8'hc7
// self-test status
`define SAR_LEFT_MAX 4'h9
`define SAR_TEST_RUNNING 4'hf
`endif

// file: src/sar_mem.sv
`timescale 1ns/1ps
module sar_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	// clock
	input wire logic clock,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port, one cycle latency
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// no reset: a location read before it has been written returns unknown
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem_reg[wr_addr] <= wr_data;
		rd_data <= mem_reg[rd_addr];
	end
endmodule : sar_mem

// file: src/sar_pkg.sv
package sar_pkg;
	typedef enum logic [2:0] {
		SAR_IDLE = 3'b001,
		SAR_FILL = 3'b010,
		SAR_READY = 3'b100
	} sar_state_t;
	// low bits of the off-line status byte
	typedef enum logic [2:0] {
		SAR_OFF_NEVER = 3'h0,
		SAR_OFF_DONE = 3'h2,
		SAR_OFF_RUNNING = 3'h3,
		SAR_OFF_SUSPENDED = 3'h4,
		SAR_OFF_HOST_ABORT = 3'h5,
		SAR_OFF_DEV_ABORT = 3'h6
	} sar_offline_t;
	// byte 0 of the entry sits in the low bits
	typedef struct packed {
		logic [7:0] zero;
		logic [47:0] raw;
		logic [7:0] worst;
		logic [7:0] value;
		logic [15:0] flags;
		logic [7:0] id;
	} sar_entry_t;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] subcommand_select_register;
		logic [15:0] command_signature_register;
	} sar_taskfile_t;
	typedef struct packed {
		sar_offline_t offline_state;
		logic auto_offline;
		logic [3:0] selftest_status;
		logic [3:0] selftest_left;
		logic [15:0] offline_seconds;
		logic [7:0] checkpoint;
		logic [7:0] short_poll;
		logic [7:0] ext_poll;
	} sar_health_t;
	typedef struct packed {
		sar_state_t st;
		logic [7:0] word;
		logic phase;
		logic [4:0] ent;
		logic [2:0] sub;
		logic [7:0] csum;
		logic intrq;
		logic prefail;
		logic advisory;
	} sar_core_t;
endpackage : sar_pkg

// file: src/sar_readout.sv
// What this block does
// [RULE1] answer attribute read with exactly one 512-byte data-in block
// [RULE2] busy while filling buffer, then data request, busy off, interrupt
// [RULE3] host loads subcommand code and signature before writing the opcode
// [RULE4] bytes 2 to 361 hold thirty consecutive attribute entries
// [RULE5] byte 362 off-line status, 363 self-test status, 364-365 seconds
// [RULE6] bytes 372 and 373 give short and extended polling minutes
// [RULE7] bit 0 of byte 370 reads one: error logging supported
// [RULE8] bytes 0 and 1 carry revision 0010h
// [RULE9] byte 511 is checksum over the first 511 bytes
// [RULE10] each entry is twelve bytes, packed back to back
// [RULE11] entry: id, flags, value, worst, six raw bytes, zero byte
// [RULE12] flag bit 0 picks pre-failure or advisory below threshold
// [RULE13] flag bit 1 clear means updated only during off-line collection
// [RULE14] flag bits 2-5 kinds, bits 6-15 reserved zero
// [RULE15] normalized value 01h-FDh, initial 64h, 00h/FEh/FFh unused
// [RULE16] crc error count id 199 starts at C8h
// [RULE17] worst value kept between 01h and FEh
// [RULE18] raw value FFFFFh means saturated
// [RULE19] identifier zero marks an unused slot
// [RULE20] identifiers have fixed meanings such as 194 and 198
// [RULE21] off-line byte 00/80 never, 02/82 done, 03/83 running
// [RULE22] off-line byte 04/84 suspended, 05/85 aborted by host
// [RULE23] off-line byte 06/86 device fatal abort, others reserved
// [RULE24] self-test byte: low nibble tenths left 0-9, high nibble status
// [RULE25] task file registers are left as the host wrote them
`timescale 1ns/1ps
`include "sar_map.svh"
module sar_readout (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// task file, written by the host adapter
	input wire logic cmd_wr,
	input wire sar_pkg::sar_taskfile_t task_file,
	input wire logic status_rd,
	// data-in handshake
	output logic bsy,
	output logic drq,
	output logic intrq,
	input wire logic data_rd,
	output logic [15:0] data_out,
	// attribute updates from drive firmware
	input wire logic attr_wr,
	input wire logic [4:0] attr_slot,
	input wire logic attr_fresh,
	input wire sar_pkg::sar_entry_t attr_in,
	input wire logic [7:0] attr_threshold,
	// live health status
	input wire sar_pkg::sar_health_t health,
	// threshold alerts
	input wire logic alert_clr,
	output logic prefail_alert,
	output logic advisory_alert
);
	sar_pkg::sar_core_t core_reg;
	sar_pkg::sar_core_t core_next;
	sar_pkg::sar_entry_t clean;
	sar_pkg::sar_entry_t attr_rd;
	logic accept;
	logic attr_take;
	logic buf_we;
	logic [15:0] buf_wdata;
	logic [7:0] buf_raddr;
	logic [7:0] lo;
	logic [7:0] hi;
	logic intrq_set;
	logic below;

	////////////////////////////////////////////////////////////////////////////
	// one byte of the block; off is the byte offset inside the current entry
	function automatic logic [7:0] byte_at(input logic [8:0] b, input logic [3:0] off,
		input sar_pkg::sar_entry_t e, input sar_pkg::sar_health_t h);
		logic [7:0] r;
		r = 8'h00;
		if (b < 9'h002)
			r = b[0] ? 8'(`SAR_REVISION >> 8) : 8'(`SAR_REVISION); // RULE8
		else if (b <= `SAR_ATTR_LAST_BYTE)
			r = e[{off, 3'b000} +: 8]; // RULE4 RULE10 RULE11
		else if (b == `SAR_B_OFFLINE)
			r = (h.auto_offline ? `SAR_AUTO_BIT : 8'h00) | {5'h00, h.offline_state}; // RULE21 RULE22 RULE23
		else if (b == `SAR_B_SELFTEST)
			r = {h.selftest_status, (h.selftest_left > `SAR_LEFT_MAX) ? `SAR_LEFT_MAX : h.selftest_left}; // RULE24
		else if (b == `SAR_B_TIME_LO)
			r = h.offline_seconds[7:0]; // RULE5
		else if (b == `SAR_B_TIME_HI)
			r = h.offline_seconds[15:8]; // RULE5
		else if (b == `SAR_B_OFFLINE_CAP)
			r = `SAR_OFFLINE_CAP;
		else if (b == `SAR_B_CAP_LO)
			r = 8'(`SAR_SMART_CAP);
		else if (b == `SAR_B_CAP_HI)
			r = 8'(`SAR_SMART_CAP >> 8);
		else if (b == `SAR_B_ERRLOG)
			r = `SAR_ERRLOG_CAP; // RULE7
		else if (b == `SAR_B_CHECKPOINT)
			r = h.checkpoint;
		else if (b == `SAR_B_SHORT_POLL)
			r = h.short_poll; // RULE6
		else if (b == `SAR_B_EXT_POLL)
			r = h.ext_poll; // RULE6
		return r;
	endfunction : byte_at

	////////////////////////////////////////////////////////////////////////////
	// attribute table, cleaned on the way in

	sar_attr_clean u_clean (
		.entry_in(attr_in),
		.fresh(attr_fresh),
		.entry_out(clean)
	);

	// an off-line-only attribute is refused unless collection is running
	assign attr_take = attr_wr && (attr_slot < 5'(`SAR_SLOTS)) &&
		(attr_in.flags[`SAR_FLAG_ONLINE] || health.offline_state == sar_pkg::SAR_OFF_RUNNING); // RULE13

	sar_mem #(
		.WIDTH(96),
		.DEPTH(`SAR_SLOTS),
		.AW(5)
	) u_attr (
		.clock(clock),
		.wr_en(attr_take),
		.wr_addr(attr_slot),
		.wr_data(clean),
		.rd_addr(core_reg.ent),
		.rd_data(attr_rd)
	);

	////////////////////////////////////////////////////////////////////////////
	// sector buffer

	assign buf_raddr = (core_reg.st == sar_pkg::SAR_READY) ? core_reg.word : 8'h00;

	sar_mem #(
		.WIDTH(16),
		.DEPTH(256),
		.AW(8)
	) u_buf (
		.clock(clock),
		.wr_en(buf_we),
		.wr_addr(core_reg.word),
		.wr_data(buf_wdata),
		.rd_addr(buf_raddr),
		.rd_data(data_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// command decode; the task file is only read, never written back
	assign accept = cmd_wr && (task_file.cmd == `SAR_CMD_HEALTH) &&
		(task_file.subcommand_select_register == `SAR_SUB_READ_ATTR) &&
		(task_file.command_signature_register == `SAR_SIGNATURE) &&
		(core_reg.st != sar_pkg::SAR_FILL); // RULE3 RULE25

	assign below = (clean.value >= `SAR_VAL_MIN) && (clean.value <= `SAR_VAL_MAX) &&
		(clean.value < attr_threshold);

	always_comb
	begin
		core_next = core_reg;
		buf_we = 1'b0;
		buf_wdata = 16'h0000;
		intrq_set = 1'b0;
		lo = byte_at({core_reg.word, 1'b0}, {core_reg.sub, 1'b0}, attr_rd, health);
		hi = byte_at({core_reg.word, 1'b1}, {core_reg.sub, 1'b1}, attr_rd, health);
		case (core_reg.st)
			sar_pkg::SAR_IDLE:
			begin
				if (accept)
				begin
					core_next.st = sar_pkg::SAR_FILL; // RULE2
					core_next.word = 8'h00;
					core_next.phase = 1'b0;
					core_next.ent = 5'h00;
					core_next.sub = 3'h0;
					core_next.csum = 8'h00;
				end
			end
			sar_pkg::SAR_FILL:
			begin
				// two cycles per word: the table read lands in the second
				if (!core_reg.phase)
					core_next.phase = 1'b1;
				else
				begin
					core_next.phase = 1'b0;
					buf_we = 1'b1;
					if (core_reg.word == `SAR_LAST_WORD)
					begin
						buf_wdata = {8'h00 - core_reg.csum - lo, lo}; // RULE9
						core_next.st = sar_pkg::SAR_READY; // RULE2
						core_next.word = 8'h00;
						intrq_set = 1'b1; // RULE2
					end
					else
					begin
						buf_wdata = {hi, lo};
						core_next.csum = core_reg.csum + lo + hi; // RULE9
						core_next.word = core_reg.word + 8'h01;
						if (core_reg.word >= `SAR_ATTR_FIRST_WORD && core_reg.word <= `SAR_ATTR_LAST_WORD)
						begin
							if (core_reg.sub == `SAR_ENTRY_LAST_WORD)
							begin
								core_next.sub = 3'h0; // RULE10
								core_next.ent = core_reg.ent + 5'h01;
							end
							else
								core_next.sub = core_reg.sub + 3'h1;
						end
					end
				end
			end
			sar_pkg::SAR_READY:
			begin
				if (accept)
				begin
					core_next.st = sar_pkg::SAR_FILL;
					core_next.word = 8'h00;
					core_next.phase = 1'b0;
					core_next.ent = 5'h00;
					core_next.sub = 3'h0;
					core_next.csum = 8'h00;
				end
				else if (data_rd)
				begin
					if (core_reg.word == `SAR_LAST_WORD)
						core_next.st = sar_pkg::SAR_IDLE; // RULE1
					else
						core_next.word = core_reg.word + 8'h01;
				end
			end
			default:
				core_next.st = sar_pkg::SAR_IDLE;
		endcase
		// a set in the same cycle as a clear wins
		core_next.intrq = intrq_set || (core_reg.intrq && !status_rd && !accept);
		core_next.prefail = (attr_take && below && clean.flags[`SAR_FLAG_PREFAIL]) ||
			(core_reg.prefail && !alert_clr); // RULE12
		core_next.advisory = (attr_take && below && !clean.flags[`SAR_FLAG_PREFAIL]) ||
			(core_reg.advisory && !alert_clr); // RULE12
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			core_reg <= '{st: sar_pkg::SAR_IDLE, default: '0};
		else
			core_reg <= core_next;
	end

	assign bsy = (core_reg.st == sar_pkg::SAR_FILL);
	assign drq = (core_reg.st == sar_pkg::SAR_READY);
	assign intrq = core_reg.intrq;
	assign prefail_alert = core_reg.prefail;
	assign advisory_alert = core_reg.advisory;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	logic [9:0] fill_cnt_reg;
	logic [9:0] read_cnt_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			fill_cnt_reg <= 10'h000;
			read_cnt_reg <= 10'h000;
		end
		else
		begin
			fill_cnt_reg <= bsy ? fill_cnt_reg + 10'h001 : 10'h000;
			if (accept)
				read_cnt_reg <= 10'h000;
			else if (drq && data_rd)
				read_cnt_reg <= read_cnt_reg + 10'h001;
		end
	end

	a_fill_starts: assert property (accept && !bsy |=> bsy && !drq) // RULE2
		else $error("accepted command did not raise busy");
	a_fill_length: assert property ($fell(bsy) |-> $past(fill_cnt_reg) == 10'h1ff) // RULE1
		else $error("buffer fill did not take 512 cycles");
	a_ready_after: assert property ($fell(bsy) && !$past(accept) |-> drq && intrq) // RULE2
		else $error("data request or interrupt missing after fill");
	a_block_words: assert property ($fell(drq) && !bsy |-> read_cnt_reg == `SAR_BLOCK_WORDS) // RULE1
		else $error("block ended after a word count other than 256");
	a_revision_word: assert property (buf_we && core_reg.word == 8'h00 |-> buf_wdata == `SAR_REVISION) // RULE8
		else $error("revision word wrong");
	a_errlog_bit: assert property (buf_we && core_reg.word == `SAR_W_ERRLOG |-> buf_wdata[0]) // RULE7
		else $error("error logging bit not set");
	a_checksum_sum: assert property (buf_we && core_reg.word == `SAR_LAST_WORD |-> // RULE9
		8'(core_reg.csum + buf_wdata[7:0] + buf_wdata[15:8]) == 8'h00)
		else $error("block bytes do not sum to zero");
	a_worst_range: assert property (attr_take && clean.id != `SAR_ID_UNUSED |-> // RULE17
		clean.worst >= `SAR_VAL_MIN && clean.worst <= `SAR_WORST_MAX)
		else $error("worst value out of range");
	a_crc_start: assert property (attr_take && attr_fresh && attr_in.id == `SAR_ID_CRC_ERRORS |-> // RULE16
		clean.value == `SAR_VAL_INIT_CRC)
		else $error("crc attribute start value wrong");
	a_raw_saturate: assert property (attr_take |-> clean.raw <= `SAR_RAW_SAT) // RULE18
		else $error("raw value above saturation");
	a_unused_slot: assert property (attr_take && attr_in.id == `SAR_ID_UNUSED |-> clean == '0) // RULE19
		else $error("unused slot not cleared");
	a_flag_reserved: assert property (attr_take |-> clean.flags[15:6] == 10'h000) // RULE14
		else $error("reserved flag bits set");
	a_offline_gate: assert property (attr_wr && !attr_in.flags[`SAR_FLAG_ONLINE] && // RULE13
		health.offline_state != sar_pkg::SAR_OFF_RUNNING |-> !attr_take)
		else $error("off-line attribute updated outside collection");
	a_busy_excl: assert property (!(bsy && drq)) // RULE2
		else $error("busy and data request both high");
	a_ready_intrq: assert property ($rose(drq) |-> intrq) // RULE2
		else $error("data request rose without interrupt");
	a_intrq_clear: assert property (intrq && status_rd && !bsy |=> !intrq) // RULE2
		else $error("interrupt not cleared by status read");
	a_last_read: assert property (drq && data_rd && !accept && core_reg.word == `SAR_LAST_WORD |=> // RULE1
		!drq && !bsy)
		else $error("data request stayed up after the last word");
	// an entry slot never written since power-up reads unknown here
	a_entry_zero: assert property (buf_we && core_reg.word >= `SAR_ATTR_FIRST_WORD && // RULE11
		core_reg.word <= `SAR_ATTR_LAST_WORD && core_reg.sub == `SAR_ENTRY_LAST_WORD |-> buf_wdata[15:8] == 8'h00)
		else $error("entry reserved byte not zero");
	a_status_byte: assert property (buf_we && core_reg.word == `SAR_W_STATUS |-> buf_wdata[6:3] == 4'h0) // RULE21
		else $error("off-line status byte has reserved bits set");
	a_tenths_left: assert property (buf_we && core_reg.word == `SAR_W_STATUS |-> // RULE24
		buf_wdata[11:8] <= `SAR_LEFT_MAX)
		else $error("self-test time left above nine tenths");
	a_alert_clear: assert property (alert_clr && !attr_take |=> !prefail_alert && !advisory_alert) // RULE12
		else $error("alert survived a clear");
	a_fresh_value: assert property (attr_take && attr_fresh && attr_in.id != `SAR_ID_UNUSED |-> // RULE15
		clean.value == `SAR_VAL_INIT || clean.value == `SAR_VAL_INIT_CRC)
		else $error("fresh attribute value not an initial value");

	c_accept: cover property (accept ##1 bsy);
	c_full_read: cover property ($fell(drq) && read_cnt_reg == `SAR_BLOCK_WORDS);
	c_crc_fresh: cover property (attr_take && attr_fresh && attr_in.id == `SAR_ID_CRC_ERRORS);
	c_prefail: cover property ($rose(prefail_alert));
	c_restart: cover property (drq && accept ##1 bsy);
endmodule : sar_readout

// file: verif/sar_host_model.sv
`timescale 1ns/1ps
module sar_host_model (
	// clock
	input wire logic clock,
	// task file side
	output logic cmd_wr,
	output sar_pkg::sar_taskfile_t task_file,
	output logic status_rd,
	// data-in handshake
	input wire logic bsy,
	input wire logic drq,
	output logic data_rd,
	input wire logic [15:0] data_out
);
	logic [15:0] blk [256];
	initial
	begin
		cmd_wr = 1'b0;
		task_file = '0;
		status_rd = 1'b0;
		data_rd = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// fields are loaded together with the opcode strobe
	task automatic issue(input logic [7:0] op, input logic [7:0] sub, input logic [15:0] sig);
		@(negedge clock);
		task_file = '{cmd: op, subcommand_select_register: sub, command_signature_register: sig};
		cmd_wr = 1'b1;
		@(negedge clock);
		cmd_wr = 1'b0;
	endtask : issue
	// counts busy cycles until data request, bounded so a dead device cannot hang the run
	task automatic wait_ready(output int busy_n);
		busy_n = 0;
		for (int i = 0; i < 2000 && drq !== 1'b1; i++)
		begin
			if (bsy === 1'b1)
				busy_n++;
			@(negedge clock);
		end
	endtask : wait_ready
	// gap of at least one idle cycle: a read right after a read would see the old word
	task automatic read_block(input int gap);
		for (int w = 0; w < 256; w++)
		begin
			blk[w] = data_out;
			data_rd = 1'b1;
			@(negedge clock);
			data_rd = 1'b0;
			repeat (gap) @(negedge clock);
		end
	endtask : read_block
	task automatic ack();
		@(negedge clock);
		status_rd = 1'b1;
		@(negedge clock);
		status_rd = 1'b0;
	endtask : ack
endmodule : sar_host_model

// file: verif/sar_readout_tb.sv
`timescale 1ns/1ps
module sar_readout_tb;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cmd_wr, status_rd, data_rd, bsy, drq, intrq, prefail_alert, advisory_alert;
	logic attr_wr = 1'b0;
	logic attr_fresh = 1'b0;
	logic alert_clr = 1'b0;
	logic [4:0] attr_slot = 5'h00;
	logic [7:0] attr_threshold = 8'h00;
	logic [15:0] data_out;
	sar_pkg::sar_taskfile_t task_file;
	sar_pkg::sar_entry_t attr_in = '0;
	sar_pkg::sar_health_t health = '0;
	sar_pkg::sar_entry_t tab [30];
	logic [7:0] b [512];
	logic pf_exp = 1'b0;
	logic adv_exp = 1'b0;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	always #50 clock = ~clock;
	sar_readout dut_u (.clock, .rstn, .cmd_wr, .task_file, .status_rd, .bsy, .drq, .intrq, .data_rd,
		.data_out, .attr_wr, .attr_slot, .attr_fresh, .attr_in, .attr_threshold, .health, .alert_clr,
		.prefail_alert, .advisory_alert);
	sar_host_model host_u (.clock, .cmd_wr, .task_file, .status_rd, .bsy, .drq, .data_rd, .data_out);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic close_out();
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			error_cnt++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic sar_pkg::sar_entry_t clean(sar_pkg::sar_entry_t e, logic f);
		sar_pkg::sar_entry_t c;
		c = e;
		c.flags = e.flags & 16'h003f;
		c.zero = 8'h00;
		if (e.raw > 48'h0000000fffff)
			c.raw = 48'h0000000fffff;
		if (f)
		begin
			c.value = (e.id == 8'hc7) ? 8'hc8 : 8'h64;
			c.worst = c.value;
		end
		else
		begin
			if (e.value >= 8'h01 && e.value <= 8'hfd && e.value < c.worst)
				c.worst = e.value;
			if (c.worst == 8'h00)
				c.worst = 8'h01;
			else if (c.worst == 8'hff)
				c.worst = 8'hfe;
		end
		if (e.id == 8'h00)
			c = '0;
		return c;
	endfunction : clean
	function automatic sar_pkg::sar_entry_t rnd_entry(int s);
		sar_pkg::sar_entry_t e;
		e = {$urandom, $urandom, $urandom};
		case (s)
			0: e.id = 8'hc7;
			1: e.id = 8'h00;
			2: e.id = 8'hc2;
			3: e.id = 8'hc6;
			4: e.raw = 48'h0000000fffff;
			5: e.raw = 48'h000000100000;
			default: ;
		endcase
		return e;
	endfunction : rnd_entry
	function automatic void build();
		logic [7:0] sum;
		sum = 8'h00;
		foreach (b[i])
			b[i] = 8'h00;
		{b[1], b[0]} = 16'h0010;
		for (int s = 0; s < 30; s++)
			for (int i = 0; i < 12; i++)
				b[2 + 12 * s + i] = tab[s][8 * i +: 8];
		b[362] = {health.auto_offline, 4'h0, health.offline_state};
		b[363] = {health.selftest_status, (health.selftest_left > 4'h9) ? 4'h9 : health.selftest_left};
		{b[365], b[364]} = health.offline_seconds;
		b[367] = 8'h5b;
		b[368] = 8'h03;
		b[370] = 8'h01;
		b[371] = health.checkpoint;
		b[372] = health.short_poll;
		b[373] = health.ext_poll;
		for (int i = 0; i < 511; i++)
			sum += b[i];
		b[511] = -sum;
	endfunction : build
	////////////////////////////////////////////////////////////////
	// alerts are checked two cycles on, so either landing edge of the update is accepted
	task automatic wr(input logic [4:0] s, input sar_pkg::sar_entry_t e, input logic f, input logic [7:0] t);
		sar_pkg::sar_entry_t c;
		@(negedge clock);
		{attr_wr, attr_slot, attr_in, attr_fresh, attr_threshold} = {1'b1, s, e, f, t};
		c = clean(e, f);
		if (s < 5'h1e && (e.flags[1] || health.offline_state == sar_pkg::SAR_OFF_RUNNING))
		begin
			tab[s] = c;
			if (c.value >= 8'h01 && c.value <= 8'hfd && c.value < t)
			begin
				pf_exp |= c.flags[0];
				adv_exp |= !c.flags[0];
			end
		end
		@(negedge clock);
		attr_wr = 1'b0;
		@(negedge clock);
		chk(prefail_alert, pf_exp);
		chk(advisory_alert, adv_exp);
	endtask : wr
	task automatic readout(input int ebusy, input int gap);
		int bc;
		host_u.wait_ready(bc);
		chk(16'(bc), 16'(ebusy));
		chk({bsy, drq, intrq}, 3'b011);
		build();
		host_u.read_block(gap);
		chk(drq, 1'b0);
		for (int w = 0; w < 256; w++)
			chk(host_u.blk[w], {b[2 * w + 1], b[2 * w]});
		host_u.ack();
		chk(intrq, 1'b0);
	endtask : readout
	////////////////////////////////////////////////////////////////
	initial
	begin
		n = $urandom(10413);
		repeat (8) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		health.offline_state = sar_pkg::SAR_OFF_RUNNING;
		// the table is not cleared by reset, so every slot is written first
		for (int s = 0; s < 30; s++)
			wr(5'(s), rnd_entry(s), s < 3, 8'($urandom));
		for (int k = 0; k < 6; k++)
		begin
			@(negedge clock);
			alert_clr = 1'b1;
			health = 52'({$urandom, $urandom});
			health.offline_state = sar_pkg::sar_offline_t'((k == 0) ? 0 : k + 1);
			@(negedge clock);
			alert_clr = 1'b0;
			pf_exp = 1'b0;
			adv_exp = 1'b0;
			repeat (6) wr(5'($urandom), rnd_entry(9), 1'($urandom), 8'($urandom));
			wr(5'h1e, rnd_entry(9), 1'b0, 8'hff);
			wr(5'h07, rnd_entry(9) & ~96'h0000_0000_0000_0000_0000_0200, 1'b0, 8'h80);
			if (k == 0)
			begin
				host_u.issue(8'hb0, 8'hd1, 16'hc24f);
				host_u.issue(8'hb0, 8'hd0, 16'hc24e);
				host_u.issue(8'hec, 8'hd0, 16'hc24f);
				@(negedge clock);
				chk({bsy, drq, intrq}, 3'b000);
			end
			host_u.issue(8'hb0, 8'hd0, 16'hc24f);
			// a second command during the fill must not restart it
			if (k == 1)
				host_u.issue(8'hb0, 8'hd0, 16'hc24f);
			// a command while data is offered drops the offer and fills again
			if (k == 2)
			begin
				host_u.wait_ready(n);
				host_u.issue(8'hb0, 8'hd0, 16'hc24f);
				chk({bsy, drq, intrq}, 3'b100);
			end
			readout((k == 1) ? 510 : 512, k % 3 + 1);
		end
		close_out();
	end
endmodule : sar_readout_tb
